// ==== rtl/adm_core.sv ====
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module adm_core
    import adm_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int RW = RAW_W
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter pins
    input wire logic conv_clk,
    input wire logic power_select_low,
    input wire logic power_select_high,
    input wire logic ref_above_high,
    input wire logic ref_below_low,
    input wire logic [RW-1:0] raw_first_channel,
    input wire logic [RW-1:0] raw_second_channel,
    // Result outputs
    output logic [DW-1:0] result_bus,
    output logic result_bus_oe,
    output logic channel_is_first
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [1:0] clk_s;
        logic [1:0] pl_s;
        logic [1:0] ph_s;
        logic [1:0] rh_s;
        logic [1:0] rl_s;
        logic [RW-1:0] ra1;
        logic [RW-1:0] ra2;
        logic [RW-1:0] rb1;
        logic [RW-1:0] rb2;
        logic clk_prev;
        logic [PIPE_LEN-1:0][2*DW-1:0] pipe;
        logic [DW-1:0] bus;
        logic oe;
        logic ind;
        adm_ref_t ref_mode;
        adm_pwr_t pwr;
        logic [7:0] trim;
        logic [15:0] count;
        logic [DW-1:0] last_a;
        logic [DW-1:0] last_b;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } adm_st_t;

    adm_st_t s_q;
    adm_st_t s_d;
    logic conv_rise;
    logic conv_fall;
    logic adc_on;
    logic out_on;
    logic apb_setup;
    logic apb_write;
    logic [DW-1:0] corr_a;
    logic [DW-1:0] corr_b;

    // ==========================================================
    // Correction: residue plus trim, clamped to the code range.
    function automatic logic [DW-1:0] correct(input logic [RW-1:0] raw,
                                              input logic [7:0] trim);
        logic signed [RW+1:0] sum;
        logic signed [RW+1:0] hi;
        logic signed [RW+1:0] lo;
        logic [DW-1:0] code;
        sum = $signed({raw[RW-1], raw[RW-1], raw})
            + $signed({{(RW+2-8){trim[7]}}, trim});
        hi = $signed((RW+2)'((1 << (DW-1)) - 1));
        lo = -$signed((RW+2)'(1 << (DW-1)));
        if (sum > hi)
        begin
            sum = hi;
        end
        else if (sum < lo)
        begin
            sum = lo;
        end
        code = sum[DW-1:0];
        code[DW-1] = ~code[DW-1];
        return code;
    endfunction

    assign conv_rise = s_q.clk_s[1] & ~s_q.clk_prev;
    assign conv_fall = ~s_q.clk_s[1] & s_q.clk_prev;
    assign apb_setup = psel & ~penable;
    assign apb_write = psel & penable & s_q.pready & pwrite;
    assign corr_a = correct(s_q.ra2, s_q.trim);
    assign corr_b = correct(s_q.rb2, s_q.trim);

    // ==========================================================
    // Power decode
    always_comb
    begin
        case (s_q.pwr)
            ADM_PWR_SHUTDOWN:
            begin
                adc_on = 1'b0;
                out_on = 1'b0;
            end
            ADM_PWR_STANDBY:
            begin
                adc_on = 1'b0;
                out_on = 1'b0;
            end
            ADM_PWR_IDLE:
            begin
                adc_on = 1'b1;
                out_on = 1'b0;
            end
            ADM_PWR_NORMAL:
            begin
                adc_on = 1'b1;
                out_on = 1'b1;
            end
            default:
            begin
                adc_on = 1'b0;
                out_on = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        s_d = s_q;
        s_d.clk_s = {s_q.clk_s[0], conv_clk};
        s_d.pl_s = {s_q.pl_s[0], power_select_low};
        s_d.ph_s = {s_q.ph_s[0], power_select_high};
        s_d.rh_s = {s_q.rh_s[0], ref_above_high};
        s_d.rl_s = {s_q.rl_s[0], ref_below_low};
        s_d.ra1 = raw_first_channel;
        s_d.ra2 = s_q.ra1;
        s_d.rb1 = raw_second_channel;
        s_d.rb2 = s_q.rb1;
        s_d.clk_prev = s_q.clk_s[1];
        s_d.pwr = adm_pwr_t'({s_q.pl_s[1], s_q.ph_s[1]});
        s_d.oe = out_on;
        if (s_q.rh_s[1])
        begin
            s_d.ref_mode = ADM_REF_INT;
        end
        else if (s_q.rl_s[1])
        begin
            s_d.ref_mode = ADM_REF_UNBUF;
        end
        else
        begin
            s_d.ref_mode = ADM_REF_BUF;
        end
        if (conv_rise)
        begin
            s_d.ind = 1'b1;
        end
        else if (conv_fall)
        begin
            s_d.ind = 1'b0;
        end
        if (adc_on && (conv_rise || conv_fall))
        begin
            for (int i = PIPE_LEN - 1; i > 0; i--)
            begin
                s_d.pipe[i] = s_q.pipe[i-1];
            end
            if (conv_rise)
            begin
                s_d.pipe[0] = {corr_b, corr_a};
                s_d.count = 16'(s_q.count + 16'h0001);
                s_d.bus = s_q.pipe[LAT_A_HALF-1][DW-1:0];
                s_d.last_a = s_q.pipe[LAT_A_HALF-1][DW-1:0];
            end
            else
            begin
                s_d.bus = s_q.pipe[LAT_B_HALF-1][2*DW-1:DW];
                s_d.last_b = s_q.pipe[LAT_B_HALF-1][2*DW-1:DW];
            end
        end
        s_d.pready = apb_setup;
        s_d.pslverr = 1'b0;
        s_d.prdata = 32'h0000_0000;
        if (apb_setup && !pwrite)
        begin
            case (paddr)
                OFS_CTRL: s_d.prdata[7:0] = s_q.trim;
                OFS_STATUS:
                begin
                    s_d.prdata[STAT_REF_POS +: 2] = s_q.ref_mode;
                    s_d.prdata[STAT_PWR_POS +: 2] = s_q.pwr;
                    s_d.prdata[STAT_OE_POS] = s_q.oe;
                end
                OFS_DATA:
                begin
                    s_d.prdata[DW-1:0] = s_q.last_a;
                    s_d.prdata[DATA_B_POS +: DW] = s_q.last_b;
                end
                OFS_COUNT: s_d.prdata[15:0] = s_q.count;
                default: s_d.pslverr = 1'b1;
            endcase
        end
        else if (apb_setup)
        begin
            s_d.pslverr = (paddr != OFS_CTRL);
        end
        if (apb_write && paddr == OFS_CTRL)
        begin
            s_d.trim = pwdata[7:0];
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
            s_q.ref_mode <= ADM_REF_INT;
            s_q.trim <= TRIM_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign result_bus = s_q.bus;
    assign result_bus_oe = s_q.oe;
    assign channel_is_first = s_q.ind;

    // ==========================================================
    // Assertions
    sequence s_apb_setup;
        psel && !penable;
    endsequence

    sequence s_apb_access;
        psel && penable && pready;
    endsequence

    a_ind_rise_high: assert property (@(posedge pclk) disable iff (!presetn)
        conv_rise |=> channel_is_first)
        else $error("Indicator not high after converter rise.");

    a_ind_fall_low: assert property (@(posedge pclk) disable iff (!presetn)
        conv_fall |=> !channel_is_first)
        else $error("Indicator not low after converter fall.");

    a_oe_normal_only: assert property (@(posedge pclk) disable iff (!presetn)
        !(s_q.pl_s[1] && s_q.ph_s[1]) |=> ##1 !result_bus_oe)
        else $error("Outputs driven outside normal mode.");

    a_hold_when_off: assert property (@(posedge pclk) disable iff (!presetn)
        !adc_on |=> $stable(result_bus))
        else $error("Result changed while converter off.");

    a_midscale_code: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_rise && adc_on && (int'($signed(s_q.ra2)) + int'($signed(s_q.trim))) == 0)
        |=> s_q.pipe[0][DW-1:0] == MIDSCALE)
        else $error("Bipolar zero not at midscale.");

    a_clamp_top: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_rise && adc_on && (int'($signed(s_q.ra2)) + int'($signed(s_q.trim))) > 127)
        |=> s_q.pipe[0][DW-1:0] == 8'hFF)
        else $error("Over-range residue not clamped.");

    a_clamp_bottom: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_rise && adc_on && (int'($signed(s_q.ra2)) + int'($signed(s_q.trim))) < -128)
        |=> s_q.pipe[0][DW-1:0] == 8'h00)
        else $error("Under-range residue not clamped.");

    a_a_latency: assert property (@(posedge pclk) disable iff (!presetn)
        (conv_rise && adc_on) |=> result_bus == $past(s_q.pipe[9][DW-1:0]))
        else $error("First channel word has wrong latency.");

    a_ref_internal: assert property (@(posedge pclk) disable iff (!presetn)
        s_q.rh_s[1] |=> s_q.ref_mode == ADM_REF_INT)
        else $error("High reference level not internal mode.");

    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        s_apb_setup |=> pready ##1 !pready)
        else $error("Access phase ready not a single cycle.");

    a_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (s_apb_setup ##0 (paddr > OFS_COUNT)) |=> s_apb_access ##0 pslverr)
        else $error("Unmapped address not flagged.");

endmodule

// ==== shared/adm_pkg.sv ====
// Operation
// - Both channels sampled together on rising edge.
// - Seven stages, advanced every half clock.
// - Latency five cycles A, five and half B.
// - Shared bus: A on rise, B on fall.
// - Indicator high for A updates, low for B.
// - Eight-bit offset binary output words.
// - Reference mode chosen from reference input level.
// - Floating reference input selects internal mode; the code selects ADM_REF_BUF.
// - Digital correction guarantees no missing codes.
// - Power inputs decode four modes; outputs tri-state.
// - Re-enabled outputs show last converted word.
// - Most significant bit on highest data line.
package adm_pkg;

    // ==========================================================
    // Widths and latency
    localparam int DATA_W = 8;
    localparam int RAW_W = 9;
    localparam int CONV_STAGES = 7;
    localparam int LAT_A_HALF = 10;
    localparam int LAT_B_HALF = 11;
    localparam int PIPE_LEN = LAT_B_HALF;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_COUNT = 8'h0C;
    localparam int STAT_REF_POS = 0;
    localparam int STAT_PWR_POS = 2;
    localparam int STAT_OE_POS = 4;
    localparam int DATA_B_POS = 8;
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [7:0] MIDSCALE = 8'h80;

    // ==========================================================
    // Modes
    typedef enum logic [1:0] {
        ADM_REF_INT = 2'b00,
        ADM_REF_BUF = 2'b01,
        ADM_REF_UNBUF = 2'b10
    } adm_ref_t;

    typedef enum logic [1:0] {
        ADM_PWR_SHUTDOWN = 2'b00,
        ADM_PWR_STANDBY = 2'b01,
        ADM_PWR_IDLE = 2'b10,
        ADM_PWR_NORMAL = 2'b11
    } adm_pwr_t;

endpackage

// ==== test/adm_rx_model.sv ====
`timescale 1ns/1ps
// ==========
// Receiver that latches each word when the channel indicator toggles.
module adm_rx_model
    import adm_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Converter outputs
    input wire logic [DATA_W-1:0] result_bus,
    input wire logic result_bus_oe,
    input wire logic channel_is_first,
    // Captured words
    output logic word_valid,
    output logic word_is_first,
    output logic [DATA_W-1:0] word
);
    logic ind_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ind_q <= 1'h0;
            word_valid <= 1'h0;
            word_is_first <= 1'h0;
            word <= 8'h00;
        end
        else
        begin
            ind_q <= channel_is_first;
            word_valid <= result_bus_oe && (channel_is_first != ind_q);
            word_is_first <= channel_is_first;
            word <= result_bus;
        end
    end
endmodule

// ==== test/adm_core_tb_top.sv ====
`timescale 1ns/1ps
module adm_core_tb_top
    import adm_pkg::*;
;
    localparam int NS = 40;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
    logic [7:0] paddr = 8'h00, trim = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic conv_clk = 1'h0, power_select_low = 1'h1, power_select_high = 1'h1;
    logic ref_above_high = 1'h1, ref_below_low = 1'h0;
    logic [RAW_W-1:0] raw_a = 9'h000, raw_b = 9'h000, ra, rb;
    logic [DATA_W-1:0] result_bus, word, last_b = 8'h00, last_a = 8'h00;
    logic result_bus_oe, channel_is_first, word_valid, word_is_first;
    logic [33:0] rd_q[$];
    logic [33:0] r;
    logic [8:0] wd_q[$];
    logic [8:0] e;
    int bad_count = 0, n_compared = 0, rises = 0;

    adm_core i_adm_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_clk(conv_clk), .power_select_low(power_select_low),
        .power_select_high(power_select_high), .ref_above_high(ref_above_high),
        .ref_below_low(ref_below_low), .raw_first_channel(raw_a), .raw_second_channel(raw_b),
        .result_bus(result_bus), .result_bus_oe(result_bus_oe),
        .channel_is_first(channel_is_first));
    adm_rx_model i_adm_rx_model (.pclk(pclk), .presetn(presetn), .result_bus(result_bus),
        .result_bus_oe(result_bus_oe), .channel_is_first(channel_is_first),
        .word_valid(word_valid), .word_is_first(word_is_first), .word(word));

    initial forever #20 pclk = ~pclk;

    // ==========
    // Helpers.
    function automatic logic [7:0] enc(input logic [8:0] raw, input logic [7:0] tr);
        int s;
        s = $signed(raw) + $signed(tr);
        if (s > 127)
            s = 127;
        if (s < -128)
            s = -128;
        enc = {~s[7], s[6:0]};
    endfunction

    task automatic chk(input logic c, input string m);
        n_compared++;
        if (c !== 1'h1)
        begin
            bad_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic print_verdict();
        $display("compared %0d bad %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic err, input logic cd);
        int g;
        rd_q.push_back({err, cd, d});
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        g = 0;
        do
        begin
            @(posedge pclk);
            g++;
        end
        while (pready !== 1'h1);
        chk(g == 1, "pready latency");
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    // ==========
    // Monitors.
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'h1)
        begin
            r = rd_q.pop_front();
            chk(pslverr === r[33], "pslverr");
            if (r[32])
                chk(prdata === r[31:0], "prdata");
        end
        if (word_valid === 1'h1)
        begin
            if (word_is_first)
                rises++;
            if (rises > 5)
            begin
                e = wd_q.pop_front();
                chk({word_is_first, word} === e, "word");
                if (!e[8])
                    last_b = e[7:0];
                else
                    last_a = e[7:0];
            end
        end
    end

    initial
    begin
        #800000;
        chk(1'h0, "timeout");
        print_verdict();
    end

    // ==========
    // Main sequence.
    initial
    begin
        void'($urandom(62));
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        repeat (4) @(posedge pclk);
        apb(1'h0, OFS_CTRL, 32'h0, 1'h0, 1'h1);
        apb(1'h0, OFS_STATUS, 32'h1C, 1'h0, 1'h1);
        trim = 8'($urandom);
        apb(1'h1, OFS_CTRL, {24'h0, trim}, 1'h0, 1'h0);
        apb(1'h1, OFS_STATUS, {24'h0, ~trim}, 1'h1, 1'h0);
        apb(1'h0, 8'h10, 32'h0, 1'h1, 1'h0);
        apb(1'h0, OFS_CTRL, {24'h0, trim}, 1'h0, 1'h1);
        for (int i = 0; i < NS + 6; i++)
        begin
            ra = 9'($urandom);
            if (i == 0)
                ra = 9'(-int'($signed(trim)));
            else if (i == 1)
                ra = 9'h0FF;
            else if (i == 2)
                ra = 9'h100;
            rb = 9'($urandom);
            raw_a <= ra;
            raw_b <= rb;
            wd_q.push_back({1'h1, enc(ra, trim)});
            wd_q.push_back({1'h0, enc(rb, trim)});
            repeat (4) @(posedge pclk);
            conv_clk <= 1'h1;
            repeat (4) @(posedge pclk);
            conv_clk <= 1'h0;
        end
        repeat (8) @(posedge pclk);
        chk(wd_q.size() == 10, "word count");
        apb(1'h0, OFS_DATA, {16'h0, last_b, last_a}, 1'h0, 1'h1);
        apb(1'h0, OFS_COUNT, NS + 6, 1'h0, 1'h1);
        for (int i = 0; i < 4; i++)
        begin
            {ref_above_high, ref_below_low} <= i[1:0];
            repeat (4) @(posedge pclk);
            apb(1'h0, OFS_STATUS, 32'h1C | ((i == 0) ? 32'h1 : (i == 1) ? 32'h2 : 32'h0),
                1'h0, 1'h1);
        end
        for (int i = 0; i < 4; i++)
        begin
            {power_select_low, power_select_high} <= i[1:0];
            repeat (6) @(posedge pclk);
            chk(result_bus_oe === (i == 3), "oe");
            apb(1'h0, OFS_STATUS, {27'h0, i == 3, i[1:0], 2'h0}, 1'h0, 1'h1);
        end
        chk(result_bus === last_b, "held word");
        print_verdict();
    end
endmodule
